// *** core/fcb_pkg.sv ***
// What this block does
// RULE1: Tap weight bits 11:0, signed two's complement
// RULE2: Seventh-tap register at 0x425, resets zero
// RULE3: Sixth tap feeds channel A or single
// RULE4: Register 0x425 feeds seventh tap
// RULE5: Register 0x427 feeds eighth tap
// RULE6: Register 0x429 feeds ninth, final tap
// RULE7: Bits 15:12 reserved, RW, ignored by filter
// RULE8: Nine taps; centre 18 bits, others 12
// RULE9: Channel B uses separate set, dual only
// RULE10: Writes touch one tap, update datapath cleanly
package fcb_pkg;

   // Register port geometry
   localparam int FCB_ADDR_W = 12;
   localparam int FCB_DATA_W = 16;

   // Filter shape
   localparam int FCB_NUM_TAPS = 9;
   localparam int FCB_CENTRE_TAP = 5;
   localparam int FCB_CENTRE_W = 18;
   localparam int FCB_TAP_W = 12;
   localparam int FCB_FIRST_TAP = 6;
   localparam int FCB_BANK_TAPS = 4;

   // Register offsets, sixth to ninth tap
   localparam logic [11:0] FCB_OFF_TAP6 = 12'h423;
   localparam logic [11:0] FCB_OFF_TAP7 = 12'h425;
   localparam logic [11:0] FCB_OFF_TAP8 = 12'h427;
   localparam logic [11:0] FCB_OFF_TAP9 = 12'h429;
   localparam logic [3:0][11:0] FCB_TAP_OFFS = {FCB_OFF_TAP9, FCB_OFF_TAP8,
                                                FCB_OFF_TAP7, FCB_OFF_TAP6};

   // Field positions
   localparam int FCB_W_MSB = 11;
   localparam int FCB_W_LSB = 0;
   localparam int FCB_RSV_MSB = 15;
   localparam int FCB_RSV_LSB = 12;

   // Values after reset and for unmapped reads
   localparam logic [15:0] FCB_COEF_RST = 16'h0000;
   localparam logic [15:0] FCB_RD_UNMAPPED = 16'h0000;

   // Read answer latency in clock cycles
   localparam int FCB_RD_LAT = 1;

   // Signed tap weight
   typedef logic signed [11:0] fcb_weight_t;

   // Register access request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [11:0] addr;
      logic [15:0] wdata;
   } fcb_reg_req_t;

   // Register access answer
   typedef struct packed {
      logic ack;
      logic hit;
      logic [15:0] rdata;
   } fcb_reg_rsp_t;

   // Four weights, index 0 is the sixth tap
   typedef struct packed {
      fcb_weight_t [3:0] w;
   } fcb_tap_bank_t;

   // Converter channel mode
   typedef enum logic [0:0] {
      FCB_MODE_DUAL = 1'b0,
      FCB_MODE_SINGLE = 1'b1
   } fcb_mode_t;

endpackage : fcb_pkg

// *** core/fcb_coef_cell.sv ***
`timescale 1ns/1ps
module fcb_coef_cell #(
   parameter logic [11:0] OFFSET = fcb_pkg::FCB_OFF_TAP6
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register request
   input wire fcb_pkg::fcb_reg_req_t req,
   // Stored word and write hit
   output logic [15:0] q,
   output logic wr_hit
);
   import fcb_pkg::*;

   logic [15:0] coef_ff; // Whole word, reserved bits included
   logic [15:0] nxt_coef;

   // Address match for this cell only
   assign wr_hit = req.wr && (req.addr == OFFSET);
   assign q = coef_ff;

   // Next value: only a write to this offset changes it
   always_comb begin
      nxt_coef = coef_ff;
      if (wr_hit) begin
         nxt_coef = req.wdata; // Reserved bits kept as written [RULE7] [RULE10]
      end
   end

   // Register with synchronous clear
   always_ff @(posedge clk) begin
      if (rst) begin
         coef_ff <= FCB_COEF_RST; // [RULE2] [RULE7]
      end else begin
         coef_ff <= nxt_coef;
      end
   end

endmodule : fcb_coef_cell

// *** core/fcb_bank_top.sv ***
`timescale 1ns/1ps
module fcb_bank_top (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire fcb_pkg::fcb_reg_req_t reg_req,
   output fcb_pkg::fcb_reg_rsp_t reg_rsp,
   // Channel mode from the mode register
   input wire fcb_pkg::fcb_mode_t chan_mode,
   // Weights toward the filters
   output fcb_pkg::fcb_tap_bank_t chan_a_taps,
   output fcb_pkg::fcb_tap_bank_t single_taps,
   // Status toward the datapath
   output logic chan_b_enable,
   output logic taps_updated
);
   import fcb_pkg::*;

   // Cell outputs
   logic [3:0][15:0] coef_q; // Raw words, index 0 is sixth tap
   logic [3:0] wr_hit; // Per-cell write match

   // Answer path
   fcb_reg_rsp_t rsp_ff;
   fcb_reg_rsp_t nxt_rsp;

   // Filter-facing state
   fcb_tap_bank_t chan_a_ff;
   fcb_tap_bank_t nxt_chan_a;
   fcb_tap_bank_t single_ff;
   fcb_tap_bank_t nxt_single;
   logic chan_b_en_ff;
   logic nxt_chan_b_en;
   logic upd_ff;
   logic nxt_upd;

   // One cell per 12-bit tap of the upper half [RULE8]
   genvar gi;
   generate
      for (gi = 0; gi < FCB_BANK_TAPS; gi++) begin : g_cell
         fcb_coef_cell #(
            .OFFSET(FCB_TAP_OFFS[gi])
         ) u_cell (
            .clk(clk),
            .rst(rst),
            .req(reg_req),
            .q(coef_q[gi]),
            .wr_hit(wr_hit[gi])
         );
      end
   endgenerate

   // Read decode; same-cycle write shows old word
   always_comb begin
      nxt_rsp = '0;
      nxt_rsp.ack = reg_req.rd;
      nxt_rsp.rdata = FCB_RD_UNMAPPED; // Unmapped reads as zero
      if (reg_req.rd) begin
         for (int i = 0; i < FCB_BANK_TAPS; i++) begin
            if (reg_req.addr == FCB_TAP_OFFS[i]) begin
               nxt_rsp.hit = 1'b1;
               nxt_rsp.rdata = coef_q[i]; // Reserved bits read back [RULE7]
            end
         end
      end
   end

   // Route weights by mode; only bits 11:0 reach a filter
   always_comb begin
      nxt_chan_a = '0;
      nxt_single = '0;
      for (int i = 0; i < FCB_BANK_TAPS; i++) begin
         if (chan_mode == FCB_MODE_DUAL) begin
            // Channel A filter in dual mode [RULE3] [RULE4] [RULE5] [RULE6]
            nxt_chan_a.w[i] = $signed(coef_q[i][FCB_W_MSB:FCB_W_LSB]); // [RULE1] [RULE7]
         end else begin
            // Single filter in single mode [RULE3] [RULE4] [RULE5] [RULE6]
            nxt_single.w[i] = $signed(coef_q[i][FCB_W_MSB:FCB_W_LSB]); // [RULE1] [RULE7]
         end
      end
   end

   // Status: channel B set is in use only in dual mode
   always_comb begin
      nxt_chan_b_en = (chan_mode == FCB_MODE_DUAL); // [RULE9]
      nxt_upd = |wr_hit; // Datapath told a tap changed [RULE10]
   end

   // Register all outputs
   always_ff @(posedge clk) begin
      if (rst) begin
         rsp_ff <= '0;
         chan_a_ff <= '0;
         single_ff <= '0;
         chan_b_en_ff <= 1'b0;
         upd_ff <= 1'b0;
      end else begin
         rsp_ff <= nxt_rsp;
         chan_a_ff <= nxt_chan_a;
         single_ff <= nxt_single;
         chan_b_en_ff <= nxt_chan_b_en;
         upd_ff <= nxt_upd;
      end
   end

   // Outputs straight from flip-flops
   assign reg_rsp = rsp_ff;
   assign chan_a_taps = chan_a_ff;
   assign single_taps = single_ff;
   assign chan_b_enable = chan_b_en_ff;
   assign taps_updated = upd_ff;

   // Reset clears every stored word and both filter weight sets
   property p_rst_clear;
      @(posedge clk) rst |=> (chan_a_ff == '0) && (single_ff == '0) && (coef_q == '0);
   endproperty
   a_rst_clear: assert property (p_rst_clear) // [RULE2]
      else $error("weights not zero after reset");

   // Seventh tap word written then read back whole
   property p_tap7_rdback;
      @(posedge clk) disable iff (rst)
      (reg_req.wr && reg_req.addr == FCB_OFF_TAP7)
      ##1 (reg_req.rd && !reg_req.wr && reg_req.addr == FCB_OFF_TAP7)
      |=> rsp_ff.ack && rsp_ff.hit && (rsp_ff.rdata == $past(reg_req.wdata, 2));
   endproperty
   a_tap7_rdback: assert property (p_tap7_rdback) // [RULE2]
      else $error("seventh tap readback mismatch");

   // Sign of the sixth weight follows bit 11
   property p_sign;
      @(posedge clk) disable iff (rst)
      (chan_mode == FCB_MODE_DUAL)
      |=> (($signed(chan_a_ff.w[0]) < 0) == $past(coef_q[0][FCB_W_MSB]));
   endproperty
   a_sign: assert property (p_sign) // [RULE1]
      else $error("weight not treated as signed");

   // Sixth tap routed by mode
   property p_tap6;
      @(posedge clk) disable iff (rst)
      (chan_mode == FCB_MODE_SINGLE)
      |=> (single_ff.w[0] == $past(coef_q[0][FCB_W_MSB:FCB_W_LSB])) && (chan_a_ff.w[0] == 0);
   endproperty
   a_tap6: assert property (p_tap6) // [RULE3]
      else $error("sixth tap not on single filter");

   // Seventh tap reaches channel A in dual mode
   property p_tap7;
      @(posedge clk) disable iff (rst)
      (chan_mode == FCB_MODE_DUAL)
      |=> (chan_a_ff.w[1] == $past(coef_q[1][FCB_W_MSB:FCB_W_LSB])) && (single_ff.w[1] == 0);
   endproperty
   a_tap7: assert property (p_tap7) // [RULE4]
      else $error("seventh tap not on channel A");

   // Eighth tap: written value appears two cycles later
   property p_tap8;
      @(posedge clk) disable iff (rst)
      (reg_req.wr && reg_req.addr == FCB_OFF_TAP8 && chan_mode == FCB_MODE_SINGLE)
      ##1 (chan_mode == FCB_MODE_SINGLE && !wr_hit[2])
      |=> single_ff.w[2] == $past(reg_req.wdata[FCB_W_MSB:FCB_W_LSB], 2);
   endproperty
   a_tap8: assert property (p_tap8) // [RULE5]
      else $error("eighth tap write not applied");

   // Ninth tap reaches channel A in dual mode
   property p_tap9;
      @(posedge clk) disable iff (rst)
      (chan_mode == FCB_MODE_DUAL) |=> chan_a_ff.w[3] == $past(coef_q[3][FCB_W_MSB:FCB_W_LSB]);
   endproperty
   a_tap9: assert property (p_tap9) // [RULE6]
      else $error("ninth tap not on channel A");

   // Reserved bits do not move a weight
   property p_rsv;
      @(posedge clk) disable iff (rst)
      (wr_hit[0] && reg_req.wdata[FCB_W_MSB:FCB_W_LSB] == coef_q[0][FCB_W_MSB:FCB_W_LSB]
       && chan_mode == FCB_MODE_DUAL) ##1 (chan_mode == FCB_MODE_DUAL)
      |=> $stable(chan_a_ff.w[0]);
   endproperty
   a_rsv: assert property (p_rsv) // [RULE7]
      else $error("reserved bits changed a weight");

   // Channel B enable follows mode
   property p_chan_b;
      @(posedge clk) disable iff (rst)
      (chan_mode == FCB_MODE_SINGLE) |=> !chan_b_en_ff;
   endproperty
   a_chan_b: assert property (p_chan_b) // [RULE9]
      else $error("channel B enabled in single mode");

   // A seventh-tap write touches only its own tap and flags update
   property p_no_corrupt;
      @(posedge clk) disable iff (rst)
      (reg_req.wr && reg_req.addr == FCB_OFF_TAP7)
      |=> $stable(coef_q[0]) && $stable(coef_q[2]) && $stable(coef_q[3]) && upd_ff;
   endproperty
   a_no_corrupt: assert property (p_no_corrupt) // [RULE10]
      else $error("write disturbed another tap");

endmodule : fcb_bank_top

// *** tb/fcb_bank_top_tb.sv ***
`timescale 1ns/1ps
module fcb_bank_top_tb;
   import fcb_pkg::*;
   // Clock, reset and request side
   logic clk;
   logic rst;
   fcb_reg_req_t reg_req;
   fcb_mode_t chan_mode;
   // Observed outputs
   fcb_reg_rsp_t reg_rsp;
   fcb_tap_bank_t chan_a_taps;
   fcb_tap_bank_t single_taps;
   logic chan_b_enable;
   logic taps_updated;
   // Tallies
   int error_cnt;
   int checked;
   // Expected stored words, index 0 is the sixth tap
   logic [15:0] word_q [4];

   // Unit under test
   fcb_bank_top uut (
      .clk(clk),
      .rst(rst),
      .reg_req(reg_req),
      .reg_rsp(reg_rsp),
      .chan_mode(chan_mode),
      .chan_a_taps(chan_a_taps),
      .single_taps(single_taps),
      .chan_b_enable(chan_b_enable),
      .taps_updated(taps_updated)
   );

   // Free-running 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Single comparison point
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // One write; update pulse is looked at in the cycle after
   task automatic reg_write(input logic [11:0] addr, input logic [15:0] data, input logic hit);
      @(negedge clk);
      reg_req.wr = 1'b1;
      reg_req.addr = addr;
      reg_req.wdata = data;
      @(negedge clk);
      reg_req.wr = 1'b0;
      chk("taps_updated", {15'h0000, hit}, {15'h0000, taps_updated});
   endtask : reg_write

   // One read; answer stands for the single following cycle
   task automatic reg_read(input logic [11:0] addr, input logic [15:0] exp, input logic hit);
      @(negedge clk);
      reg_req.rd = 1'b1;
      reg_req.addr = addr;
      @(negedge clk);
      reg_req.rd = 1'b0;
      chk("ack", 16'h0001, {15'h0000, reg_rsp.ack});
      chk("hit", {15'h0000, hit}, {15'h0000, reg_rsp.hit});
      chk("rdata", exp, reg_rsp.rdata);
   endtask : reg_read

   // Write, then a read of the same offset in the very next cycle
   task automatic reg_write_read(input logic [11:0] addr, input logic [15:0] data);
      @(negedge clk);
      reg_req.wr = 1'b1;
      reg_req.addr = addr;
      reg_req.wdata = data;
      @(negedge clk);
      reg_req.wr = 1'b0;
      reg_req.rd = 1'b1;
      chk("taps_updated", 16'h0001, {15'h0000, taps_updated});
      @(negedge clk);
      reg_req.rd = 1'b0;
      chk("ack", 16'h0001, {15'h0000, reg_rsp.ack});
      chk("hit", 16'h0001, {15'h0000, reg_rsp.hit});
      chk("rdata", data, reg_rsp.rdata);
   endtask : reg_write_read

   // Weights toward both filters, sign-extended, plus channel B status
   task automatic chk_taps(input fcb_mode_t m);
      fcb_weight_t w;
      for (int i = 0; i < 4; i++) begin
         w = word_q[i][11:0];
         chk("chan_a_tap", (m == FCB_MODE_DUAL) ? 16'(w) : 16'h0000,
             16'($signed(chan_a_taps.w[i])));
         chk("single_tap", (m == FCB_MODE_SINGLE) ? 16'(w) : 16'h0000,
             16'($signed(single_taps.w[i])));
      end
      chk("chan_b_enable", {15'h0000, m == FCB_MODE_DUAL}, {15'h0000, chan_b_enable});
   endtask : chk_taps

   // All four registers read back against the expected words
   task automatic read_all;
      for (int i = 0; i < 4; i++) begin
         reg_read(FCB_TAP_OFFS[i], word_q[i], 1'b1);
      end
   endtask : read_all

   // Closing report
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : print_verdict

   // Main sequence
   initial begin
      rst = 1'b1;
      reg_req = '0;
      chan_mode = FCB_MODE_DUAL;
      error_cnt = 0;
      checked = 0;
      word_q = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
      repeat (2) @(negedge clk);
      rst = 1'b0;
      // Everything clear after reset
      read_all();
      chk_taps(FCB_MODE_DUAL);
      // Negative, extreme and reserved-bit patterns, one idle cycle apart
      word_q = '{16'hF801, 16'hA7FF, 16'h5FFF, 16'h0123};
      for (int i = 0; i < 4; i++) begin
         reg_write(FCB_TAP_OFFS[i], word_q[i], 1'b1);
      end
      @(negedge clk);
      chk_taps(FCB_MODE_DUAL);
      read_all();
      // Unmapped holes between taps change nothing
      reg_write(12'h424, 16'hFFFF, 1'b0);
      reg_write(12'h426, 16'hFFFF, 1'b0);
      reg_read(12'h424, 16'h0000, 1'b0);
      @(negedge clk);
      chk_taps(FCB_MODE_DUAL);
      read_all();
      // Reserved-only change on tap6, then tap7 written and read straight after
      word_q[0] = 16'h0801;
      reg_write(FCB_OFF_TAP6, word_q[0], 1'b1);
      word_q[1] = 16'hC3A5;
      reg_write_read(FCB_OFF_TAP7, word_q[1]);
      @(negedge clk);
      chk_taps(FCB_MODE_DUAL);
      // Single-channel mode routes the same words to the single filter
      chan_mode = FCB_MODE_SINGLE;
      @(negedge clk);
      chk_taps(FCB_MODE_SINGLE);
      // Reserved bits alone change: stored, never seen by the filter
      word_q[2] = 16'h8FFF;
      reg_write(FCB_OFF_TAP8, word_q[2], 1'b1);
      @(negedge clk);
      chk_taps(FCB_MODE_SINGLE);
      reg_read(FCB_OFF_TAP8, 16'h8FFF, 1'b1);
      // Reset in mid-run clears every word again
      rst = 1'b1;
      @(negedge clk);
      rst = 1'b0;
      word_q = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
      chk_taps(FCB_MODE_SINGLE);
      read_all();
      print_verdict();
   end
endmodule : fcb_bank_top_tb
